// ---- hw/radio_mode_ctrl.sv ----
// Operating mode, addressing, channel access and sleep controller
//
// The register addresses and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/10ps
module radio_mode_ctrl #(
  parameter int LFSR_SEED = 16'hACE1
) (
  input wire logic CORE_CLK_I,
  input wire logic RESET_I,
  input wire logic [3:0] AXI_AWADDR_I,
  input wire logic AXI_AWVALID_I,
  output logic AXI_AWREADY_O,
  input wire logic [31:0] AXI_WDATA_I,
  input wire logic [3:0] AXI_WSTRB_I,
  input wire logic AXI_WVALID_I,
  output logic AXI_WREADY_O,
  output logic [1:0] AXI_BRESP_O,
  output logic AXI_BVALID_O,
  input wire logic AXI_BREADY_I,
  input wire logic [3:0] AXI_ARADDR_I,
  input wire logic AXI_ARVALID_I,
  output logic AXI_ARREADY_O,
  output logic [31:0] AXI_RDATA_O,
  output logic [1:0] AXI_RRESP_O,
  output logic AXI_RVALID_O,
  input wire logic AXI_RREADY_I,
  input wire logic SERIAL_INPUT_BUFFER_READY_I,
  input wire logic RADIO_RX_VALID_I,
  input wire logic RADIO_RX_DONE_I,
  input wire logic RADIO_RX_ADDRESSED_I,
  input wire logic RADIO_RX_POLL_I,
  input wire logic [63:0] RADIO_RX_SRC_I,
  input wire logic [7:0] CHANNEL_ENERGY_I,
  input wire logic RADIO_TX_DONE_I,
  input wire logic RADIO_ACK_I,
  input wire logic SLEEP_REQUEST_PIN_I,
  input wire logic ASSOC_BUSY_I,
  output logic [4:0] MODE_O,
  output logic TX_START_O,
  output logic POLL_START_O,
  output radio_mode_pkg::hdr_t TX_HDR_O,
  output logic TX_CONSUME_O,
  output logic FLOW_READY_N_O
);
  // ======================================================================
  // State
  // ======================================================================
  typedef struct packed {
    radio_mode_pkg::mode_t mode;
    radio_mode_pkg::txph_t ph;
    logic [31:0] ctrl;
    logic [15:0] src_short;
    logic [31:0] ser_hi;
    logic [31:0] ser_lo;
    logic [31:0] dst_hi;
    logic [31:0] dst_lo;
    logic [15:0] sleep_per;
    logic [15:0] idle_time;
    logic [15:0] tick_cnt;
    logic [15:0] idle_cnt;
    logic [15:0] sleep_cnt;
    logic [15:0] direct_cnt;
    logic [63:0] direct_addr;
    logic direct_ok;
    logic [11:0] wait_cnt;
    logic [15:0] lfsr;
    logic [1:0] cca_left;
    logic [1:0] ack_left;
    logic ack_fail;
    logic cca_fail;
    logic pin_prev;
    logic pin_woke;
    logic poll_pend;
    logic cmd_req;
    logic cmd_exit;
    radio_mode_pkg::slot_t [1:0] slot;
    radio_mode_pkg::hdr_t hdr;
    logic tx_start;
    logic poll_start;
    logic consume;
    logic flow_n;
    logic bvalid;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [1:0] bresp;
  } st_t;

  st_t s_r;
  st_t s_nxt;

  logic [2:0] sm;
  logic is_coord;
  logic tick;
  logic aw_go;
  logic ar_go;
  logic [63:0] dst_full;
  logic dst_long;
  logic bcast;
  logic pin_sleep;
  logic cyc_sleep;
  logic want_sleep;
  logic wake;
  logic [15:0] bmask;
  logic cmd_wr;
  integer i;

  // Refuse a seed that would lock the shift register at zero
  if ((LFSR_SEED < 1) || (LFSR_SEED > 65535)) begin : g_seed_check
    $error("LFSR_SEED must be a non-zero 16-bit value");
  end

  // Helpers decoded from configuration
  assign sm = s_r.ctrl[radio_mode_pkg::CTRL_SM_LSB +: 3];
  assign is_coord = s_r.ctrl[radio_mode_pkg::CTRL_COORD];
  assign tick = (s_r.tick_cnt == radio_mode_pkg::TICK_CYC - 16'h0001);
  assign dst_long = (s_r.dst_hi != 32'h0000_0000) ||
                    (s_r.dst_lo[15:0] >= radio_mode_pkg::ADDR_LIMIT) && !bcast;
  assign bcast = (s_r.dst_hi == 32'h0000_0000) &&
                 (s_r.dst_lo == {16'h0000, radio_mode_pkg::BCAST_ADDR});
  assign dst_full = {s_r.dst_hi, s_r.dst_lo};
  assign pin_sleep = (sm == radio_mode_pkg::SM_HIB) || (sm == radio_mode_pkg::SM_DOZE);
  assign cyc_sleep = (sm == radio_mode_pkg::SM_CYC) || (sm == radio_mode_pkg::SM_CYC_PIN);
  // Sleep entry conditions
  assign want_sleep = (sm != radio_mode_pkg::SM_OFF) &&
    (((pin_sleep || (sm == radio_mode_pkg::SM_CYC_PIN && !s_r.pin_woke)) &&
      SLEEP_REQUEST_PIN_I) ||
     (cyc_sleep && s_r.idle_cnt >= s_r.idle_time));
  assign bmask = 16'((17'h00001 << s_r.ctrl[radio_mode_pkg::CTRL_BE_LSB +: 3]) - 17'h00001);

  // Bus handshakes: address and data taken together, one at a time
  assign aw_go = AXI_AWVALID_I && AXI_WVALID_I && !s_r.bvalid;
  assign cmd_wr = aw_go && ({2'b00, AXI_AWADDR_I, 2'b00} == radio_mode_pkg::OFS_CMD);
  assign ar_go = AXI_ARVALID_I && !s_r.rvalid;
  assign AXI_AWREADY_O = aw_go;
  assign AXI_WREADY_O = aw_go;
  assign AXI_ARREADY_O = ar_go;
  assign AXI_BVALID_O = s_r.bvalid;
  assign AXI_BRESP_O = s_r.bresp;
  assign AXI_RVALID_O = s_r.rvalid;
  assign AXI_RDATA_O = s_r.rdata;
  assign AXI_RRESP_O = s_r.rresp;
  assign MODE_O = s_r.mode;
  assign TX_START_O = s_r.tx_start;
  assign POLL_START_O = s_r.poll_start;
  assign TX_HDR_O = s_r.hdr;
  assign TX_CONSUME_O = s_r.consume;
  assign FLOW_READY_N_O = s_r.flow_n;

  // ======================================================================
  // Next state
  // ======================================================================
  always_comb begin
    logic [7:0] a;
    logic direct;
    s_nxt = s_r;
    a = 8'h00;
    direct = 1'b0;
    wake = 1'b0;
    s_nxt.tx_start = 1'b0;
    s_nxt.poll_start = 1'b0;
    s_nxt.consume = 1'b0;
    s_nxt.pin_prev = SLEEP_REQUEST_PIN_I;
    s_nxt.lfsr = {s_r.lfsr[14:0], s_r.lfsr[15] ^ s_r.lfsr[13] ^ s_r.lfsr[12] ^ s_r.lfsr[10]};
    s_nxt.tick_cnt = tick ? 16'h0000 : s_r.tick_cnt + 16'h0001;

    // Register writes
    if (aw_go) begin
      a = {2'b00, AXI_AWADDR_I, 2'b00};
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = 2'b00;
      unique case (a)
        radio_mode_pkg::OFS_CTRL: s_nxt.ctrl = AXI_WDATA_I;
        radio_mode_pkg::OFS_SRC_SHORT: s_nxt.src_short = AXI_WDATA_I[15:0];
        radio_mode_pkg::OFS_SER_HIGH: s_nxt.ser_hi = AXI_WDATA_I;
        radio_mode_pkg::OFS_SER_LOW: s_nxt.ser_lo = AXI_WDATA_I;
        radio_mode_pkg::OFS_DST_HIGH: s_nxt.dst_hi = AXI_WDATA_I;
        radio_mode_pkg::OFS_DST_LOW: s_nxt.dst_lo = AXI_WDATA_I;
        radio_mode_pkg::OFS_SLEEP_PER: s_nxt.sleep_per = AXI_WDATA_I[15:0];
        radio_mode_pkg::OFS_IDLE_TIME: s_nxt.idle_time = AXI_WDATA_I[15:0];
        radio_mode_pkg::OFS_STATUS: ;
        radio_mode_pkg::OFS_CMD: begin
          if (AXI_WDATA_I[radio_mode_pkg::CMD_FORCE_POLL]) begin
            s_nxt.poll_pend = 1'b1;
          end
          if (AXI_WDATA_I[radio_mode_pkg::CMD_ENTER]) begin
            s_nxt.cmd_req = 1'b1;
          end
          if (AXI_WDATA_I[radio_mode_pkg::CMD_EXIT]) begin
            s_nxt.cmd_exit = 1'b1;
          end
        end
        default: s_nxt.bresp = 2'b10;
      endcase
      if (AXI_WSTRB_I != 4'hF) begin
        s_nxt.bresp = 2'b10;
      end
    end else if (AXI_BREADY_I) begin
      s_nxt.bvalid = 1'b0;
    end

    // Register reads; the ack and CCA fail flags clear on a status read, a new set wins
    if (ar_go) begin
      a = {2'b00, AXI_ARADDR_I, 2'b00};
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = 2'b00;
      unique case (a)
        radio_mode_pkg::OFS_CTRL: s_nxt.rdata = s_r.ctrl;
        radio_mode_pkg::OFS_SRC_SHORT: s_nxt.rdata = {16'h0000, s_r.src_short};
        radio_mode_pkg::OFS_SER_HIGH: s_nxt.rdata = s_r.ser_hi;
        radio_mode_pkg::OFS_SER_LOW: s_nxt.rdata = s_r.ser_lo;
        radio_mode_pkg::OFS_DST_HIGH: s_nxt.rdata = s_r.dst_hi;
        radio_mode_pkg::OFS_DST_LOW: s_nxt.rdata = s_r.dst_lo;
        radio_mode_pkg::OFS_SLEEP_PER: s_nxt.rdata = {16'h0000, s_r.sleep_per};
        radio_mode_pkg::OFS_IDLE_TIME: s_nxt.rdata = {16'h0000, s_r.idle_time};
        radio_mode_pkg::OFS_STATUS: begin
          s_nxt.rdata = {21'h00_0000, s_r.slot[1].valid, s_r.slot[0].valid, s_r.direct_ok,
                         s_r.ack_fail, s_r.cca_fail, 1'b0, s_r.mode};
          s_nxt.ack_fail = 1'b0;
          s_nxt.cca_fail = 1'b0;
        end
        radio_mode_pkg::OFS_CMD: s_nxt.rdata = 32'h0000_0000;
        default: begin
          s_nxt.rdata = 32'h0000_0000;
          s_nxt.rresp = 2'b10;
        end
      endcase
    end else if (AXI_RREADY_I) begin
      s_nxt.rvalid = 1'b0;
    end

    // Inactivity timer for the one address last heard, for direct delivery
    if (tick && s_r.direct_ok) begin
      if (s_r.direct_cnt >= s_r.idle_time) begin
        s_nxt.direct_ok = 1'b0;
      end else begin
        s_nxt.direct_cnt = s_r.direct_cnt + 16'h0001;
      end
    end
    if (((RADIO_RX_VALID_I && RADIO_RX_ADDRESSED_I) || RADIO_RX_POLL_I) && is_coord) begin
      s_nxt.direct_ok = 1'b1;
      s_nxt.direct_addr = RADIO_RX_SRC_I;
      s_nxt.direct_cnt = 16'h0000;
    end

    // Indirect slots age out after the sleep period
    for (i = 0; i < radio_mode_pkg::PEND_DEPTH; i++) begin
      if (s_r.slot[i].valid && tick) begin
        if (s_r.slot[i].age >= s_r.sleep_per) begin
          s_nxt.slot[i].valid = 1'b0;
        end else begin
          s_nxt.slot[i].age = s_r.slot[i].age + 16'h0001;
        end
      end
      if (RADIO_RX_POLL_I && s_r.slot[i].valid && s_r.slot[i].dst == RADIO_RX_SRC_I) begin
        s_nxt.slot[i].valid = 1'b0;
      end
    end

    // Idle timer, counted in ticks while idle
    if (tick && s_r.mode == radio_mode_pkg::M_IDLE && s_r.idle_cnt != 16'hFFFF) begin
      s_nxt.idle_cnt = s_r.idle_cnt + 16'h0001;
    end
    if (s_r.mode != radio_mode_pkg::M_IDLE) begin
      s_nxt.idle_cnt = 16'h0000;
    end

    // Mode machine
    unique case (s_r.mode)
      radio_mode_pkg::M_IDLE: begin
        if (s_r.cmd_req) begin
          s_nxt.cmd_req = cmd_wr && AXI_WDATA_I[radio_mode_pkg::CMD_ENTER]; // New request wins
          s_nxt.mode = radio_mode_pkg::M_CMD;
        end else if (RADIO_RX_VALID_I) begin
          s_nxt.mode = radio_mode_pkg::M_RX;
        end else if (s_r.poll_pend && !is_coord) begin
          s_nxt.poll_pend = cmd_wr && AXI_WDATA_I[radio_mode_pkg::CMD_FORCE_POLL]; // New wins
          s_nxt.poll_start = 1'b1;
        end else if (SERIAL_INPUT_BUFFER_READY_I) begin
          // Build header and choose delivery
          s_nxt.hdr.src_long = (s_r.src_short >= radio_mode_pkg::ADDR_LIMIT);
          s_nxt.hdr.src = (s_r.src_short < radio_mode_pkg::ADDR_LIMIT) ?
            {48'h0000_0000_0000, s_r.src_short} : {s_r.ser_hi, s_r.ser_lo};
          s_nxt.hdr.dst = dst_long ? dst_full : {48'h0000_0000_0000, s_r.dst_lo[15:0]};
          s_nxt.hdr.dst_long = dst_long;
          s_nxt.hdr.bcast = bcast;
          direct = !is_coord || bcast || (s_r.sleep_per == 16'h0000) ||
                   (s_r.direct_ok && s_r.direct_addr == dst_full);
          s_nxt.consume = 1'b1;
          if (direct) begin
            s_nxt.hdr.indirect = 1'b0;
            s_nxt.mode = radio_mode_pkg::M_TX;
            s_nxt.ph = radio_mode_pkg::T_BACKOFF;
            s_nxt.wait_cnt = 12'(s_r.lfsr & bmask) * {4'h0, radio_mode_pkg::BACKOFF_UNIT};
            s_nxt.cca_left = radio_mode_pkg::CCA_RETRIES;
            s_nxt.ack_left = radio_mode_pkg::ACK_RETRIES;
            if (!bcast) begin
              s_nxt.direct_cnt = 16'h0000;
            end
          end else if (!s_r.slot[0].valid) begin
            s_nxt.slot[0] = '{valid: 1'b1, age: 16'h0000, dst: dst_full};
          end else if (!s_r.slot[1].valid) begin
            s_nxt.slot[1] = '{valid: 1'b1, age: 16'h0000, dst: dst_full};
          end else begin
            s_nxt.consume = 1'b0; // Both slots full: leave data waiting
          end
        end else if (want_sleep && !ASSOC_BUSY_I) begin
          s_nxt.mode = radio_mode_pkg::M_SLEEP;
          s_nxt.flow_n = 1'b1;
          s_nxt.sleep_cnt = 16'h0000;
        end
      end
      radio_mode_pkg::M_TX: begin
        unique case (s_r.ph)
          radio_mode_pkg::T_BACKOFF: begin
            if (s_r.wait_cnt == 12'h000) begin
              s_nxt.ph = radio_mode_pkg::T_CCA;
            end else begin
              s_nxt.wait_cnt = s_r.wait_cnt - 12'h001;
            end
          end
          radio_mode_pkg::T_CCA: begin
            if (CHANNEL_ENERGY_I > s_r.ctrl[radio_mode_pkg::CTRL_CCA_LSB +: 8]) begin
              if (s_r.cca_left == 2'h0) begin
                s_nxt.cca_fail = 1'b1;
                s_nxt.mode = radio_mode_pkg::M_IDLE;
              end else begin
                s_nxt.cca_left = s_r.cca_left - 2'h1;
                s_nxt.ph = radio_mode_pkg::T_BACKOFF;
                s_nxt.wait_cnt = 12'((s_r.lfsr & bmask) | 16'h0001) *
                                 {4'h0, radio_mode_pkg::BACKOFF_UNIT};
              end
            end else begin
              s_nxt.tx_start = 1'b1;
              s_nxt.ph = radio_mode_pkg::T_SEND;
            end
          end
          radio_mode_pkg::T_SEND: begin
            if (RADIO_TX_DONE_I) begin
              if (s_r.hdr.bcast) begin
                s_nxt.mode = radio_mode_pkg::M_IDLE;
              end else begin
                s_nxt.ph = radio_mode_pkg::T_ACK;
                s_nxt.wait_cnt = {4'h0, radio_mode_pkg::ACK_WAIT};
              end
            end
          end
          radio_mode_pkg::T_ACK: begin
            if (RADIO_ACK_I) begin
              s_nxt.mode = radio_mode_pkg::M_IDLE;
            end else if (s_r.wait_cnt == 12'h000) begin
              if (s_r.ack_left == 2'h0) begin
                s_nxt.ack_fail = 1'b1;
                s_nxt.mode = radio_mode_pkg::M_IDLE;
              end else begin
                s_nxt.ack_left = s_r.ack_left - 2'h1;
                s_nxt.cca_left = radio_mode_pkg::CCA_RETRIES;
                s_nxt.ph = radio_mode_pkg::T_CCA;
              end
            end else begin
              s_nxt.wait_cnt = s_r.wait_cnt - 12'h001;
            end
          end
        endcase
      end
      radio_mode_pkg::M_RX: begin
        if (RADIO_RX_DONE_I) begin
          s_nxt.mode = radio_mode_pkg::M_IDLE;
        end
      end
      radio_mode_pkg::M_CMD: begin
        if (s_r.cmd_exit) begin
          s_nxt.cmd_exit = cmd_wr && AXI_WDATA_I[radio_mode_pkg::CMD_EXIT];
          s_nxt.mode = radio_mode_pkg::M_IDLE;
        end
      end
      radio_mode_pkg::M_SLEEP: begin
        wake = 1'b0;
        if (tick) begin
          s_nxt.sleep_cnt = s_r.sleep_cnt + 16'h0001;
        end
        if (pin_sleep && !SLEEP_REQUEST_PIN_I) begin
          wake = 1'b1;
          s_nxt.poll_pend = s_nxt.poll_pend | s_r.ctrl[radio_mode_pkg::CTRL_POLLPIN];
        end
        if (cyc_sleep && s_r.sleep_cnt >= s_r.sleep_per) begin
          wake = 1'b1;
          s_nxt.poll_pend = 1'b1;
          s_nxt.pin_woke = 1'b0;
        end
        if (sm == radio_mode_pkg::SM_CYC_PIN && s_r.pin_prev && !SLEEP_REQUEST_PIN_I) begin
          wake = 1'b1;
          s_nxt.pin_woke = 1'b1;
        end
        if (sm == radio_mode_pkg::SM_OFF) begin
          wake = 1'b1;
        end
        if (wake) begin
          s_nxt.mode = radio_mode_pkg::M_IDLE;
          s_nxt.flow_n = 1'b0;
          s_nxt.idle_cnt = 16'h0000;
        end
      end
    endcase
  end

  // ======================================================================
  // State register
  // ======================================================================
  always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      s_r <= '0;
      s_r.mode <= radio_mode_pkg::M_IDLE;
      s_r.ph <= radio_mode_pkg::T_BACKOFF;
      s_r.ctrl <= radio_mode_pkg::CTRL_RST;
      s_r.src_short <= radio_mode_pkg::SRC_SHORT_RST;
      s_r.lfsr <= 16'(LFSR_SEED);
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule

// ---- hw/radio_mode_pkg.sv ----
// Package with constants and carrier types for the radio mode controller
package radio_mode_pkg;
  // ======================================================================
  // Register map (AXI4-Lite byte addresses)
  // ======================================================================
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SRC_SHORT = 8'h04;
  localparam logic [7:0] OFS_SER_HIGH = 8'h08;
  localparam logic [7:0] OFS_SER_LOW = 8'h0C;
  localparam logic [7:0] OFS_DST_HIGH = 8'h10;
  localparam logic [7:0] OFS_DST_LOW = 8'h14;
  localparam logic [7:0] OFS_SLEEP_PER = 8'h18;
  localparam logic [7:0] OFS_IDLE_TIME = 8'h1C;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam logic [7:0] OFS_CMD = 8'h24;
  // CTRL field positions
  localparam int CTRL_SM_LSB = 0;      // sleep_mode_select [2:0]
  localparam int CTRL_COORD = 3;       // coordinator enable
  localparam int CTRL_MM_LSB = 4;      // mac_mode_select [1:0]
  localparam int CTRL_RR_LSB = 8;      // unicast_retry_setting [3:0]
  localparam int CTRL_BE_LSB = 12;     // backoff_exponent_setting [2:0]
  localparam int CTRL_POLLPIN = 15;    // end_device_assoc_options poll on pin wake
  localparam int CTRL_CCA_LSB = 16;    // channel_energy_threshold [7:0]
  // CMD bits (write one to pulse)
  localparam int CMD_FORCE_POLL = 0;
  localparam int CMD_ENTER = 1;
  localparam int CMD_EXIT = 2;
  // Reset values, address limit and broadcast address
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [15:0] SRC_SHORT_RST = 16'h0000;
  localparam logic [15:0] ADDR_LIMIT = 16'hFFFE;
  localparam logic [15:0] BCAST_ADDR = 16'hFFFF;
  // Sleep settings
  localparam logic [2:0] SM_OFF = 3'h0;
  localparam logic [2:0] SM_HIB = 3'h1;
  localparam logic [2:0] SM_DOZE = 3'h2;
  localparam logic [2:0] SM_CYC = 3'h4;
  localparam logic [2:0] SM_CYC_PIN = 3'h5;
  // Retry and queue figures
  localparam logic [1:0] CCA_RETRIES = 2'h2;
  localparam logic [1:0] ACK_RETRIES = 2'h3;
  localparam int PEND_DEPTH = 2;
  localparam logic [7:0] ACK_WAIT = 8'h40;   // Cycles to wait for an ack
  localparam logic [7:0] BACKOFF_UNIT = 8'h14; // Cycles per backoff slot
  localparam logic [31:0] TICK_NS = 32'h0000_2710; // Timer tick 10 us
  localparam int CLK_NS = 10;
  localparam logic [15:0] TICK_CYC = 16'(TICK_NS / CLK_NS);

  // Operating modes, one-hot
  typedef enum logic [4:0] {
    M_IDLE = 5'b00001,
    M_TX = 5'b00010,
    M_RX = 5'b00100,
    M_SLEEP = 5'b01000,
    M_CMD = 5'b10000
  } mode_t;

  // Transmit sub-sequence, one-hot
  typedef enum logic [3:0] {
    T_BACKOFF = 4'b0001,
    T_CCA = 4'b0010,
    T_SEND = 4'b0100,
    T_ACK = 4'b1000
  } txph_t;

  // Packet header presented to the radio
  typedef struct packed {
    logic [63:0] src;
    logic src_long;
    logic [63:0] dst;
    logic dst_long;
    logic bcast;
    logic indirect;
  } hdr_t;

  // Pending indirect message slot
  typedef struct packed {
    logic valid;
    logic [15:0] age;
    logic [63:0] dst;
  } slot_t;
endpackage

// ---- tb/radio_mode_sva.sv ----
// Port checks for the radio mode controller
`timescale 1ns/10ps
module radio_mode_sva (
  input wire logic CORE_CLK_I,
  input wire logic RESET_I,
  input wire logic AXI_AWVALID_I,
  input wire logic AXI_WVALID_I,
  input wire logic AXI_BVALID_O,
  input wire logic AXI_BREADY_I,
  input wire logic AXI_ARVALID_I,
  input wire logic AXI_RVALID_O,
  input wire logic [4:0] MODE_O,
  input wire logic TX_START_O,
  input wire logic TX_CONSUME_O,
  input wire logic SERIAL_INPUT_BUFFER_READY_I,
  input wire logic RADIO_RX_VALID_I,
  input wire logic FLOW_READY_N_O
);
  // ====
  // Clocking and write step
  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (RESET_I);
  sequence wr_taken_s;
    AXI_AWVALID_I && AXI_WVALID_I && !AXI_BVALID_O;
  endsequence
  // ====
  // Checks
  mode_one_hot_a: assert property ($onehot(MODE_O))
    else $error("mode not one-hot");
  wr_answer_a: assert property (wr_taken_s |=> AXI_BVALID_O)
    else $error("no write response");
  b_stands_a: assert property (AXI_BVALID_O && !AXI_BREADY_I |=> AXI_BVALID_O)
    else $error("write response dropped");
  rd_answer_a: assert property (AXI_ARVALID_I && !AXI_RVALID_O |=> AXI_RVALID_O)
    else $error("no read response");
  start_in_tx_a: assert property (TX_START_O |-> MODE_O == 5'h02)
    else $error("send outside transmit");
  start_pulse_a: assert property (TX_START_O |=> !TX_START_O)
    else $error("send pulse too long");
  consume_cause_a: assert property (TX_CONSUME_O |-> $past(SERIAL_INPUT_BUFFER_READY_I))
    else $error("consume without data");
  rx_entry_a: assert property ($rose(MODE_O == 5'h04) |-> $past(RADIO_RX_VALID_I))
    else $error("receive without frame");
  sleep_entry_a: assert property ($rose(MODE_O == 5'h08) |-> $past(MODE_O) == 5'h01)
    else $error("sleep not from idle");
  asleep_flag_a: assert property (MODE_O == 5'h08 |-> FLOW_READY_N_O)
    else $error("ready while asleep");
endmodule

// ---- tb/radio_peer_model.sv ----
// Peer radio answering each send with done and optional ack
`timescale 1ns/10ps
module radio_peer_model (
  input wire logic clk_i,
  input wire logic start_i,
  input wire logic ack_en_i,
  output logic tx_done_o,
  output logic ack_o
);
  logic [3:0] cnt_r = 4'h0;
  logic d_r = 1'b0;
  logic a_r = 1'b0;
  assign tx_done_o = d_r;
  assign ack_o = a_r;
  // Air time, then acknowledgement when enabled
  always @(posedge clk_i) begin
    d_r <= (cnt_r == 4'h3);
    a_r <= (cnt_r == 4'h5) && ack_en_i;
    if (start_i) cnt_r <= 4'h1;
    else if (cnt_r != 4'h0 && cnt_r != 4'h5) cnt_r <= cnt_r + 4'h1;
    else cnt_r <= 4'h0;
  end
endmodule

// ---- tb/tb.sv ----
// Self-checking bench for the radio mode controller
`timescale 1ns/10ps
module tb;
  logic clk = 0, rst = 1, aw_v = 0, w_v = 0, b_r = 0, ar_v = 0, r_r = 0;
  logic ser = 0, rxv = 0, rxd = 0, pin = 0, ack_en = 0;
  logic [3:0] aw_a = 4'h0, ar_a = 4'h0;
  logic [31:0] w_d = 32'h0000_0000, rd, r_d;
  logic [7:0] nrg = 8'h00;
  logic aw_rdy, w_rdy, b_v, ar_rdy, r_v, txs, pls, cons, frn, txd, ack;
  logic [1:0] b_resp, r_resp, rsp;
  logic [4:0] mode;
  radio_mode_pkg::hdr_t hdr, hdr_seen;
  int err_count = 0, compares = 0, starts = 0, polls = 0, cyc = 0;
  initial forever #5 clk = ~clk;
  radio_mode_ctrl radio_mode_ctrl_inst (.CORE_CLK_I(clk), .RESET_I(rst),
    .AXI_AWADDR_I(aw_a), .AXI_AWVALID_I(aw_v), .AXI_AWREADY_O(aw_rdy), .AXI_WDATA_I(w_d),
    .AXI_WSTRB_I(4'hF), .AXI_WVALID_I(w_v), .AXI_WREADY_O(w_rdy), .AXI_BRESP_O(b_resp),
    .AXI_BVALID_O(b_v), .AXI_BREADY_I(b_r), .AXI_ARADDR_I(ar_a), .AXI_ARVALID_I(ar_v),
    .AXI_ARREADY_O(ar_rdy), .AXI_RDATA_O(r_d), .AXI_RRESP_O(r_resp), .AXI_RVALID_O(r_v),
    .AXI_RREADY_I(r_r), .SERIAL_INPUT_BUFFER_READY_I(ser), .RADIO_RX_VALID_I(rxv),
    .RADIO_RX_DONE_I(rxd), .RADIO_RX_ADDRESSED_I(1'b1), .RADIO_RX_POLL_I(1'b0),
    .RADIO_RX_SRC_I(64'h0), .CHANNEL_ENERGY_I(nrg), .RADIO_TX_DONE_I(txd),
    .RADIO_ACK_I(ack), .SLEEP_REQUEST_PIN_I(pin), .ASSOC_BUSY_I(1'b0), .MODE_O(mode),
    .TX_START_O(txs), .POLL_START_O(pls), .TX_HDR_O(hdr), .TX_CONSUME_O(cons),
    .FLOW_READY_N_O(frn));
  radio_peer_model radio_peer_model_inst (.clk_i(clk), .start_i(txs | pls),
    .ack_en_i(ack_en), .tx_done_o(txd), .ack_o(ack));
  // ====
  // Shared tasks
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    aw_a <= a;
    w_d <= d;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    do @(posedge clk); while (aw_rdy !== 1'b1);
    aw_v <= 1'b0;
    w_v <= 1'b0;
    b_r <= 1'b1;
    do @(posedge clk); while (b_v !== 1'b1);
    rsp = b_resp;
    b_r <= 1'b0;
  endtask
  task automatic rdt(input logic [3:0] a);
    ar_a <= a;
    ar_v <= 1'b1;
    do @(posedge clk); while (ar_rdy !== 1'b1);
    ar_v <= 1'b0;
    r_r <= 1'b1;
    do @(posedge clk); while (r_v !== 1'b1);
    rd = r_d;
    rsp = r_resp;
    r_r <= 1'b0;
  endtask
  task automatic wm(input logic [4:0] m, input int lim);
    for (int i = 0; i < lim && mode !== m; i++) @(posedge clk);
    chk("mode", m, mode);
  endtask
  task automatic send(input int n);
    starts = 0;
    ser <= 1'b1;
    wm(5'h02, 50);
    ser <= 1'b0;
    wm(5'h01, 3000);
    chk("sends", n, starts);
  endtask
  task automatic report_and_stop();
    $display("mismatches %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Send counting and hang limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (txs === 1'b1) begin
      starts <= starts + 1;
      hdr_seen <= hdr;
    end
    if (pls === 1'b1) polls <= polls + 1;
    if (cyc == 60000) begin
      err_count++;
      report_and_stop();
    end
  end
  // ====
  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("reset mode", 5'h01, mode);
    rdt(4'h0);
    chk("ctrl reset", 32'h0000_0000, rd);
    rdt(4'hF);
    chk("unmapped", 2'h2, rsp);
    wr(4'h2, 32'h1234_5678);
    wr(4'h3, 32'h9ABC_DEF0);
    wr(4'h0, 32'h0080_0000);
    wr(4'h1, 32'h0000_0012);
    wr(4'h5, 32'h0000_FFFF);
    send(1);
    chk("short src", 64'h12, hdr_seen.src);
    chk("bcast", 1'b1, hdr_seen.bcast);
    wr(4'h1, 32'h0000_FFFE);
    wr(4'h5, 32'h0000_0034);
    send(4);
    chk("long src", 64'h1234_5678_9ABC_DEF0, hdr_seen.src);
    chk("src long", 1'b1, hdr_seen.src_long);
    chk("dst", 64'h34, hdr_seen.dst);
    chk("dst long", 1'b0, hdr_seen.dst_long);
    rdt(4'h8);
    chk("ack fail", 1'b1, rd[7]);
    ack_en <= 1'b1;
    send(1);
    nrg <= 8'hFF;
    send(0);
    rdt(4'h8);
    chk("cca fail", 1'b1, rd[6]);
    nrg <= 8'h00;
    wr(4'h7, 32'h0000_0005);
    wr(4'h0, 32'h0080_0008);
    rxv <= 1'b1;
    wm(5'h04, 20);
    rxv <= 1'b0;
    rxd <= 1'b1;
    @(posedge clk);
    rxd <= 1'b0;
    wm(5'h01, 20);
    rdt(4'h8);
    chk("direct ok", 1'b1, rd[8]);
    wr(4'h9, 32'h0000_0002);
    wm(5'h10, 20);
    wr(4'h9, 32'h0000_0004);
    wm(5'h01, 20);
    wr(4'h6, 32'h0000_0002);
    ser <= 1'b1;
    repeat (4) @(posedge clk);
    ser <= 1'b0;
    rdt(4'h8);
    chk("slots full", 2'h3, rd[10:9]);
    repeat (3100) @(posedge clk);
    rdt(4'h8);
    chk("slots aged", 2'h0, rd[10:9]);
    wr(4'h6, 32'h0000_0000);
    send(1);
    pin <= 1'b1;
    repeat (50) @(posedge clk);
    chk("no sleep", 5'h01, mode);
    wr(4'h0, 32'h0080_0001);
    wm(5'h08, 50);
    pin <= 1'b0;
    wm(5'h01, 50);
    repeat (2) @(posedge clk);
    chk("awake flag", 1'b0, frn);
    polls = 0;
    wr(4'h9, 32'h0000_0001);
    repeat (3) @(posedge clk);
    chk("force poll", 1'b1, polls == 1);
    wr(4'h7, 32'h0000_0001);
    wr(4'h6, 32'h0000_0002);
    polls = 0;
    wr(4'h0, 32'h0080_0004);
    wm(5'h08, 1500);
    wm(5'h01, 2500);
    repeat (5) @(posedge clk);
    chk("wake poll", 1'b1, polls > 0);
    wr(4'h6, 32'h0000_0100);
    wr(4'h7, 32'h0000_0003);
    wr(4'h0, 32'h0080_0005);
    wm(5'h08, 4500);
    pin <= 1'b1;
    repeat (4) @(posedge clk);
    pin <= 1'b0;
    wm(5'h01, 10);
    pin <= 1'b1;
    repeat (20) @(posedge clk);
    chk("pin ignored", 5'h01, mode);
    report_and_stop();
  end
endmodule
bind radio_mode_ctrl radio_mode_sva radio_mode_sva_inst (.CORE_CLK_I, .RESET_I,
  .AXI_AWVALID_I, .AXI_WVALID_I, .AXI_BVALID_O, .AXI_BREADY_I, .AXI_ARVALID_I,
  .AXI_RVALID_O, .MODE_O, .TX_START_O, .TX_CONSUME_O, .SERIAL_INPUT_BUFFER_READY_I,
  .RADIO_RX_VALID_I, .FLOW_READY_N_O);
